// ===== src/asc_pkg.sv
// Shared constants and types for the acquisition scan and trigger control block
package asc_pkg;

  // Channel count and field widths
  localparam int NUM_CHANNELS = 16;
  localparam int CHAN_W = 4;
  localparam int DATA_W = 12;
  localparam int ADDR_W = 5;

  // Byte offsets on the host I/O port
  localparam logic [ADDR_W-1:0] OFS_RESULT_LOW = 5'h00;
  localparam logic [ADDR_W-1:0] OFS_RESULT_HIGH = 5'h01;
  localparam logic [ADDR_W-1:0] OFS_RANGE = 5'h02;
  localparam logic [ADDR_W-1:0] OFS_SCAN_START = 5'h04;
  localparam logic [ADDR_W-1:0] OFS_SCAN_STOP = 5'h05;
  localparam logic [ADDR_W-1:0] OFS_CONTROL = 5'h06;
  localparam logic [ADDR_W-1:0] OFS_STATUS = 5'h07;
  localparam logic [ADDR_W-1:0] OFS_CLEAR_IRQ = 5'h08;
  localparam logic [ADDR_W-1:0] OFS_CLEAR_FIFO = 5'h09;
  localparam logic [ADDR_W-1:0] OFS_AOUT0_LOW = 5'h0A;
  localparam logic [ADDR_W-1:0] OFS_AOUT0_HIGH = 5'h0B;

  // Trigger pin indices in the synchroniser bank
  localparam int PIN_PACER = 0;
  localparam int PIN_OUTSIDE = 1;
  localparam int PIN_GATE = 2;
  localparam int NUM_PINS = 3;

  // Reset values
  localparam logic [7:0] CONTROL_RESET = 8'h00;
  localparam logic [DATA_W-1:0] AOUT_RESET = 12'h000;
  localparam logic [7:0] READ_IDLE = 8'h00;

  // Result word: high byte then low byte, exactly as the host sees it
  typedef struct packed {
    logic [CHAN_W-1:0] channel;
    logic [3:0] dataHigh;
    logic [7:0] dataLow;
  } asc_result_t;

  // Range code byte as written at the range offset
  typedef struct packed {
    logic [1:0] spareHigh;
    logic diff;
    logic unipolar;
    logic spareMid;
    logic [2:0] gainCode;
  } asc_range_t;

  // Control byte, read back unchanged
  typedef struct packed {
    logic spare;
    logic eventCounterClockSelect;
    logic interruptCauseSelect;
    logic interruptEnable;
    logic gateEnable;
    logic outsideTriggerEnable;
    logic pacerTriggerEnable;
    logic softwareTriggerEnable;
  } asc_ctrl_t;

  // Status byte
  typedef struct packed {
    logic [3:0] spare;
    logic irqFlag;
    logic full;
    logic halfFull;
    logic empty;
  } asc_status_t;

  // Byte that carries a 4-bit value in its low nibble
  typedef struct packed {
    logic [3:0] spare;
    logic [3:0] nibble;
  } asc_nibble_t;

endpackage

// ===== src/asc_scan_trigger.sv
// Result FIFO and the scan, trigger and register logic of the acquisition card
`timescale 1ns/1ps

// Small synchronous FIFO with valid/ready on both sides
module asc_fifo #(
  parameter int WIDTH = 16,
  parameter int DEPTH = 8
) (
  // Clock and reset
  input wire logic clk,
  input wire logic rst_n,
  // Flush
  input wire logic clear,
  // Fill side
  input wire logic inValid,
  output logic inReady,
  input wire logic [WIDTH-1:0] inData,
  // Drain side
  output logic outValid,
  input wire logic outReady,
  output logic [WIDTH-1:0] outData,
  // Fill level flags
  output logic empty,
  output logic halfFull,
  output logic full
);
  localparam int AW = (DEPTH > 1) ? $clog2(DEPTH) : 1;
  localparam int CW = $clog2(DEPTH + 1);
  localparam logic [AW-1:0] LAST_PTR = AW'(DEPTH - 1);
  localparam logic [CW-1:0] FULL_COUNT = CW'(DEPTH);
  localparam logic [CW-1:0] HALF_COUNT = CW'(DEPTH / 2);

  typedef struct packed {
    logic [DEPTH-1:0][WIDTH-1:0] mem;
    logic [AW-1:0] wrPtr;
    logic [AW-1:0] rdPtr;
    logic [CW-1:0] count;
  } asc_fifo_state_t;

  asc_fifo_state_t st;
  asc_fifo_state_t next_st;
  logic doPush;
  logic doPop;

  // Flags follow the fill count directly
  assign full = (st.count == FULL_COUNT);
  assign empty = (st.count == '0);
  assign halfFull = (st.count >= HALF_COUNT);
  assign inReady = !full;
  assign outValid = !empty;
  assign outData = st.mem[st.rdPtr];
  assign doPush = inValid && !full;
  assign doPop = outReady && !empty;

  // Pointer and count update; a flush discards a push in the same cycle
  always_comb begin
    next_st = st;
    if (clear) begin
      next_st.wrPtr = '0;
      next_st.rdPtr = '0;
      next_st.count = '0;
    end else begin
      if (doPush) begin
        next_st.mem[st.wrPtr] = inData;
        next_st.wrPtr = (st.wrPtr == LAST_PTR) ? '0 : st.wrPtr + AW'(1);
      end
      if (doPop) begin
        next_st.rdPtr = (st.rdPtr == LAST_PTR) ? '0 : st.rdPtr + AW'(1);
      end
      if (doPush && !doPop) begin
        next_st.count = st.count + CW'(1);
      end else if (doPop && !doPush) begin
        next_st.count = st.count - CW'(1);
      end
    end
  end

  // State register
  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      st <= '0;
    end else begin
      st <= next_st;
    end
  end
endmodule

module asc_scan_trigger #(
  parameter int FIFO_DEPTH = 8
) (
  // Clock and reset
  input wire logic clk,
  input wire logic rst_n,
  // Host I/O byte port
  input wire logic [asc_pkg::ADDR_W-1:0] ioAddr,
  input wire logic [7:0] ioWrData,
  input wire logic ioWr,
  input wire logic ioRd,
  output logic [7:0] ioRdData,
  // Trigger pins
  input wire logic pacerPin,
  input wire logic outsideTriggerPin,
  input wire logic outsideTriggerGatingPin,
  // Converter and multiplexer
  output logic convStart,
  output logic [asc_pkg::CHAN_W-1:0] muxChannel,
  output asc_pkg::asc_range_t rangeSel,
  input wire logic convDone,
  input wire logic [asc_pkg::DATA_W-1:0] convData,
  // Other outputs
  output logic irqRequest,
  output logic eventCounterClockSelect,
  output logic outsideGateEnable,
  output logic [asc_pkg::DATA_W-1:0] analogOutValue
);
  localparam int CW = asc_pkg::CHAN_W;
  localparam int NCH = asc_pkg::NUM_CHANNELS;
  localparam int NP = asc_pkg::NUM_PINS;

  typedef struct packed {
    asc_pkg::asc_range_t [NCH-1:0] ram;
    asc_pkg::asc_ctrl_t ctrl;
    logic [CW-1:0] startCh;
    logic [CW-1:0] stopCh;
    logic [CW-1:0] scanPtr;
    logic busy;
    logic irqFlag;
    logic halfPrev;
    logic [NP-1:0][2:0] sync;
    logic [NP-1:0] level;
    logic [NP-1:0] levelPrev;
    logic [7:0] aoutLow;
    logic [asc_pkg::DATA_W-1:0] aoutValue;
    logic [7:0] rdData;
    logic convStart;
    logic [CW-1:0] muxChannel;
    asc_pkg::asc_range_t rangeSel;
  } asc_state_t;

  asc_state_t st;
  asc_state_t next_st;
  logic [NP-1:0] pinsIn;
  logic [NP-1:0] rise;
  logic swWrite;
  logic scanWrite;
  logic irqClear;
  logic irqEvent;
  logic trigger;
  logic fifoPush;
  logic fifoPop;
  logic fifoClear;
  logic fifoInReady;
  logic fifoOutValid;
  logic fifoEmpty;
  logic fifoHalf;
  logic fifoFull;
  asc_pkg::asc_result_t fifoIn;
  asc_pkg::asc_result_t fifoOut;
  asc_pkg::asc_status_t status;
  asc_pkg::asc_nibble_t wrNibble;

  // Next scan channel, skipping the odd half of a differential pair
  function automatic logic [CW-1:0] nextChannel(
    input logic [CW-1:0] cur,
    input logic [CW-1:0] first,
    input logic [CW-1:0] last,
    input asc_pkg::asc_range_t [NCH-1:0] ram
  );
    logic [CW-1:0] n;
    n = '0;
    if (cur == last) begin
      n = first;
    end else begin
      n = cur + CW'(1);
      if (n[0] && ram[n - CW'(1)].diff) begin
        n = (n == last) ? first : n + CW'(1);
      end
    end
    return n;
  endfunction

  assign pinsIn[asc_pkg::PIN_PACER] = pacerPin;
  assign pinsIn[asc_pkg::PIN_OUTSIDE] = outsideTriggerPin;
  assign pinsIn[asc_pkg::PIN_GATE] = outsideTriggerGatingPin;
  assign rise = st.level & ~st.levelPrev;
  // Write byte viewed as a low-nibble carrier for the channel and output fields
  assign wrNibble = ioWrData;

  // Result tagged with the channel that was converted
  assign fifoIn.channel = st.muxChannel;
  assign {fifoIn.dataHigh, fifoIn.dataLow} = convData;

  // Status byte assembled from FIFO flags and the sticky flag
  always_comb begin
    status = '0;
    status.empty = fifoEmpty;
    status.halfFull = fifoHalf;
    status.full = fifoFull;
    status.irqFlag = st.irqFlag;
  end

  // Result buffer; its full flag holds off new triggers
  asc_fifo #(
    .WIDTH($bits(asc_pkg::asc_result_t)),
    .DEPTH(FIFO_DEPTH)
  ) u_result_fifo (
    .clk(clk),
    .rst_n(rst_n),
    .clear(fifoClear),
    .inValid(fifoPush),
    .inReady(fifoInReady),
    .inData(fifoIn),
    .outValid(fifoOutValid),
    .outReady(fifoPop),
    .outData(fifoOut),
    .empty(fifoEmpty),
    .halfFull(fifoHalf),
    .full(fifoFull)
  );

  // Main next-state logic
  always_comb begin
    next_st = st;
    swWrite = 1'b0;
    scanWrite = 1'b0;
    irqClear = 1'b0;
    fifoClear = 1'b0;
    fifoPush = 1'b0;
    fifoPop = 1'b0;
    next_st.convStart = 1'b0;

    // Pin synchronisers: a level counts once stages two and three agree
    for (int i = 0; i < NP; i++) begin
      next_st.sync[i] = {st.sync[i][1:0], pinsIn[i]};
      if (st.sync[i][1] == st.sync[i][2]) begin
        next_st.level[i] = st.sync[i][2];
      end
    end
    next_st.levelPrev = st.level;

    // Register writes
    if (ioWr) begin
      if (ioAddr == asc_pkg::OFS_RESULT_LOW) begin
        swWrite = 1'b1;
      end else if (ioAddr == asc_pkg::OFS_RANGE) begin
        // Start channel acts as the write pointer; spare bits kept at zero
        next_st.ram[st.startCh] = ioWrData;
        next_st.ram[st.startCh].spareHigh = '0;
        next_st.ram[st.startCh].spareMid = 1'b0;
      end else if (ioAddr == asc_pkg::OFS_SCAN_START) begin
        next_st.startCh = wrNibble.nibble;
        next_st.scanPtr = wrNibble.nibble;
        scanWrite = 1'b1;
      end else if (ioAddr == asc_pkg::OFS_SCAN_STOP) begin
        next_st.stopCh = wrNibble.nibble;
        next_st.scanPtr = st.startCh;
        scanWrite = 1'b1;
      end else if (ioAddr == asc_pkg::OFS_CONTROL) begin
        next_st.ctrl = ioWrData;
      end else if (ioAddr == asc_pkg::OFS_CLEAR_IRQ) begin
        irqClear = 1'b1;
      end else if (ioAddr == asc_pkg::OFS_CLEAR_FIFO) begin
        fifoClear = 1'b1;
      end else if (ioAddr == asc_pkg::OFS_AOUT0_LOW) begin
        next_st.aoutLow = ioWrData;
      end else if (ioAddr == asc_pkg::OFS_AOUT0_HIGH) begin
        // Low byte joins the high nibble only now, so the output never glitches
        next_st.aoutValue = {wrNibble.nibble, st.aoutLow};
      end
    end

    // Trigger selection; a busy converter or a full buffer drops the trigger
    trigger = !st.busy && fifoInReady &&
      ((st.ctrl.softwareTriggerEnable && swWrite) ||
       (st.ctrl.pacerTriggerEnable && rise[asc_pkg::PIN_PACER]) ||
       (st.ctrl.outsideTriggerEnable && rise[asc_pkg::PIN_OUTSIDE] &&
        (!st.ctrl.gateEnable || st.level[asc_pkg::PIN_GATE])));

    // Start a conversion on the current scan channel
    if (trigger) begin
      next_st.convStart = 1'b1;
      next_st.busy = 1'b1;
      next_st.muxChannel = st.scanPtr;
      next_st.rangeSel = st.ram[st.scanPtr];
      if (!scanWrite) begin
        next_st.scanPtr = nextChannel(st.scanPtr, st.startCh, st.stopCh, st.ram);
      end
    end

    // Completed conversion enters the buffer
    if (st.busy && convDone) begin
      fifoPush = 1'b1;
      next_st.busy = 1'b0;
    end

    // Register reads; data stands until the next read
    if (ioRd) begin
      if (ioAddr == asc_pkg::OFS_RESULT_LOW) begin
        next_st.rdData = fifoOutValid ? fifoOut.dataLow : asc_pkg::READ_IDLE;
      end else if (ioAddr == asc_pkg::OFS_RESULT_HIGH) begin
        next_st.rdData = fifoOutValid ? {fifoOut.channel, fifoOut.dataHigh} :
          asc_pkg::READ_IDLE;
        fifoPop = fifoOutValid && !fifoClear;
      end else if (ioAddr == asc_pkg::OFS_CONTROL) begin
        next_st.rdData = st.ctrl;
      end else if (ioAddr == asc_pkg::OFS_STATUS) begin
        next_st.rdData = status;
      end else begin
        next_st.rdData = asc_pkg::READ_IDLE;
      end
    end

    // Interrupt cause: every conversion or the rise to half full
    next_st.halfPrev = fifoHalf;
    irqEvent = st.ctrl.interruptCauseSelect ? (fifoHalf && !st.halfPrev) : fifoPush;
    if (irqClear) begin
      next_st.irqFlag = 1'b0;
    end
    // Set beats clear so a coincident event is not lost
    if (irqEvent && st.ctrl.interruptEnable) begin
      next_st.irqFlag = 1'b1;
    end
  end

  // State register
  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      st <= '0;
      st.ctrl <= asc_pkg::CONTROL_RESET;
      st.aoutValue <= asc_pkg::AOUT_RESET;
      st.rdData <= asc_pkg::READ_IDLE;
    end else begin
      st <= next_st;
    end
  end

  // Outputs straight from the state register
  assign ioRdData = st.rdData;
  assign convStart = st.convStart;
  assign muxChannel = st.muxChannel;
  assign rangeSel = st.rangeSel;
  assign irqRequest = st.irqFlag;
  assign eventCounterClockSelect = st.ctrl.eventCounterClockSelect;
  assign outsideGateEnable = st.ctrl.gateEnable;
  assign analogOutValue = st.aoutValue;
endmodule

// ===== bench/asc_scan_trigger_props.sv
// Port-level assertions for the scan and trigger block
`timescale 1ns/1ps
module asc_scan_trigger_props (
  // Clock and reset
  input wire logic clk,
  input wire logic rst_n,
  // Host port
  input wire logic [asc_pkg::ADDR_W-1:0] ioAddr,
  input wire logic [7:0] ioWrData,
  input wire logic ioWr,
  input wire logic ioRd,
  input wire logic [7:0] ioRdData,
  // Converter side
  input wire logic convStart,
  input wire logic [asc_pkg::CHAN_W-1:0] muxChannel,
  input wire asc_pkg::asc_range_t rangeSel,
  input wire logic convDone,
  // Other outputs
  input wire logic irqRequest,
  input wire logic eventCounterClockSelect,
  input wire logic outsideGateEnable,
  input wire logic [asc_pkg::DATA_W-1:0] analogOutValue
);
  logic [7:0] ctrlQ;
  logic busyQ;

  default clocking cb @(posedge clk); endclocking
  default disable iff (!rst_n);

  // Shadow control byte and in-flight flag, rebuilt from port traffic only
  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      ctrlQ <= 8'h00;
      busyQ <= 1'b0;
    end else begin
      if (ioWr && ioAddr == asc_pkg::OFS_CONTROL) begin
        ctrlQ <= ioWrData;
      end
      busyQ <= convStart | (busyQ & ~convDone);
    end
  end

  // Six quiet cycles cover the longest pin pipeline
  a_trig_off_quiet: assert property ((ctrlQ[2:0] == 3'h0) [*6] |=> !convStart)
    else $error("conversion started with all sources off");
  a_one_in_flight: assert property (busyQ |-> !convStart)
    else $error("second start while busy");
  a_ctrl_outputs: assert property ($stable(ctrlQ) [*2] |->
    outsideGateEnable == ctrlQ[3] && eventCounterClockSelect == ctrlQ[6])
    else $error("gate or counter clock output differs from control");
  a_ctrl_readback: assert property (ioRd && !ioWr && ioAddr == asc_pkg::OFS_CONTROL
    |=> ioRdData == $past(ctrlQ))
    else $error("control readback differs");
  // A half-full rise lands one cycle after the push, so the cycle after convDone is excluded
  a_irq_clear: assert property (ioWr && ioAddr == asc_pkg::OFS_CLEAR_IRQ && !convDone &&
    !$past(convDone) |=> !irqRequest)
    else $error("interrupt not cleared");
  a_irq_sticky: assert property (irqRequest && !(ioWr && ioAddr == asc_pkg::OFS_CLEAR_IRQ)
    |=> irqRequest)
    else $error("interrupt flag dropped");
  a_irq_masked: assert property (!ctrlQ[4] && !irqRequest |=> !irqRequest)
    else $error("interrupt raised while disabled");
  a_irq_per_conv: assert property (ctrlQ[4] && !ctrlQ[5] && busyQ && convDone
    |=> irqRequest)
    else $error("no interrupt after conversion");
  a_scan_hold: assert property (!convStart |-> $stable(muxChannel) && $stable(rangeSel))
    else $error("channel changed without a start");
  a_aout_update: assert property (ioWr && ioAddr == asc_pkg::OFS_AOUT0_HIGH
    |=> analogOutValue[11:8] == $past(ioWrData[3:0]))
    else $error("output high bits wrong");
endmodule

bind asc_scan_trigger asc_scan_trigger_props u_asc_scan_trigger_props (.clk, .rst_n, .ioAddr,
  .ioWrData, .ioWr, .ioRd, .ioRdData, .convStart, .muxChannel, .rangeSel, .convDone,
  .irqRequest, .eventCounterClockSelect, .outsideGateEnable, .analogOutValue);

// ===== bench/asc_scan_trigger_tb.sv
// Self-checking bench for the scan and trigger block
`timescale 1ns/1ps
module asc_scan_trigger_tb;
  logic clk = 1'b0;
  logic rst_n = 1'b0;
  logic [4:0] ioAddr = 5'h00;
  logic [7:0] ioWrData = 8'h00;
  logic ioWr = 1'b0;
  logic ioRd = 1'b0;
  logic [2:0] pins = 3'h0;
  logic convDone = 1'b0;
  logic [11:0] convData = 12'h000;
  logic [7:0] ioRdData;
  logic convStart;
  logic [3:0] muxChannel;
  asc_pkg::asc_range_t rangeSel;
  logic irqRequest;
  logic eventCounterClockSelect;
  logic outsideGateEnable;
  logic [11:0] analogOutValue;
  int errors = 0;
  int cmp_count = 0;
  int seed = 32'h4A35C282;
  // Reference model
  logic [7:0] ram [16];
  logic [7:0] ctrl, v, lo;
  logic [3:0] start, stop, ptr;
  logic irq;
  logic [11:0] aout;
  logic [15:0] q [$];

  always #10 clk = ~clk;

  asc_scan_trigger u_asc_scan_trigger (.clk, .rst_n, .ioAddr, .ioWrData, .ioWr, .ioRd,
    .ioRdData, .pacerPin(pins[0]), .outsideTriggerPin(pins[1]),
    .outsideTriggerGatingPin(pins[2]), .convStart, .muxChannel, .rangeSel, .convDone,
    .convData, .irqRequest, .eventCounterClockSelect, .outsideGateEnable, .analogOutValue);

  task automatic chk(input logic [15:0] got, input logic [15:0] exp);
    cmp_count++;
    if (got !== exp) begin
      errors++;
      $display("CHECK FAILED at %0t: got %h expected %h", $time, got, exp);
    end
  endtask

  // Next scan channel: wraps at stop, skips the odd half of a pair
  function automatic logic [3:0] nxt(input logic [3:0] p);
    do p = (p == stop) ? start : p + 4'h1;
    while (p[0] && ram[p - 4'h1][5]);
    return p;
  endfunction

  // One byte write; the model follows the same offset map
  task automatic wr(input logic [4:0] a, input logic [7:0] d);
    @(negedge clk);
    ioAddr = a;
    ioWrData = d;
    ioWr = 1'b1;
    @(negedge clk);
    ioWr = 1'b0;
    case (a)
      5'h02: ram[start] = d & 8'h37;
      5'h04: begin
        start = d[3:0];
        ptr = d[3:0];
      end
      5'h05: begin
        stop = d[3:0];
        ptr = start;
      end
      5'h06: ctrl = d;
      5'h08: irq = 1'b0;
      5'h09: q.delete();
      5'h0A: lo = d;
      5'h0B: aout = {d[3:0], lo};
      default: ;
    endcase
  endtask

  task automatic rdc(input logic [4:0] a, input logic [7:0] e);
    @(negedge clk);
    ioAddr = a;
    ioRd = 1'b1;
    @(negedge clk);
    ioRd = 1'b0;
    chk(ioRdData, e);
  endtask

  task automatic st;
    rdc(5'h07, {4'h0, irq, q.size() == 8, q.size() >= 4, q.size() == 0});
  endtask

  task automatic res;
    logic [15:0] e;
    e = (q.size() > 0) ? q[0] : 16'h0000;
    rdc(5'h00, e[7:0]);
    rdc(5'h01, e[15:8]);
    if (q.size() > 0) void'(q.pop_front());
  endtask

  // Waits for a start (or its absence), then finishes the conversion
  task automatic conv(input bit ok);
    int n;
    logic [11:0] d;
    n = 0;
    while (convStart !== 1'b1 && n < 12) begin
      @(negedge clk);
      n++;
    end
    chk(n < 12, ok);
    if (n < 12) begin
      chk(muxChannel, ptr);
      chk(rangeSel, ram[ptr]);
      d = 12'($random(seed));
      @(negedge clk);
      convData = d;
      convDone = 1'b1;
      @(negedge clk);
      convDone = 1'b0;
      q.push_back({ptr, d});
      if (ctrl[4] && (!ctrl[5] || q.size() == 4)) irq = 1'b1;
      // The half-full cause is seen one cycle after the push, so look a cycle later
      @(negedge clk);
      chk(irqRequest, irq);
      ptr = nxt(ptr);
    end
  endtask

  // Pin low for four cycles, then held high through the wait and four more cycles
  task automatic pin(input int i, input bit ok);
    repeat (4) @(negedge clk);
    pins[i] = 1'b1;
    conv(ok);
    repeat (4) @(negedge clk);
    pins[i] = 1'b0;
  endtask

  task automatic conclude;
    $display("Comparisons %0d, mismatches %0d", cmp_count, errors);
    if (errors == 0 && cmp_count > 0) begin
      $display("Run complete: PASS");
    end else begin
      $display("Run complete: FAIL");
    end
    $finish;
  endtask

  // Watchdog, well beyond the few hundred cycles the tests need
  initial begin
    #400000;
    errors++;
    conclude();
  end

  initial begin
    foreach (ram[i]) ram[i] = 8'h00;
    {ctrl, lo, start, stop, ptr, irq, aout} = '0;
    repeat (6) @(posedge clk);
    @(negedge clk);
    rst_n = 1'b1;
    repeat (4) @(negedge clk);
    st();
    rdc(5'h06, 8'h00);
    v = 8'($random(seed)) & 8'hF8;
    wr(5'h06, v);
    rdc(5'h06, v);
    chk(outsideGateEnable, v[3]);
    chk(eventCounterClockSelect, v[6]);
    wr(5'h06, 8'h00);
    $display("Test control done");
    // Every gain and polarity code once; pairs on 2, 12 and 14
    for (int c = 0; c < 16; c++) begin
      wr(5'h04, c[7:0]);
      wr(5'h05, c[7:0]);
      v = (8'($random(seed)) & 8'hC8) | {2'b00, c == 2 || c == 12 || c == 14, c[3], 1'b0, c[2:0]};
      wr(5'h02, v);
    end
    wr(5'h04, 8'h0E);
    wr(5'h05, 8'h03);
    wr(5'h00, v);
    conv(1'b0);
    wr(5'h06, 8'h01);
    for (int k = 0; k < 8; k++) begin
      wr(5'h00, v);
      conv(1'b1);
    end
    st();
    wr(5'h00, v);
    conv(1'b0);
    for (int k = 0; k < 9; k++) res();
    st();
    $display("Test scan done");
    wr(5'h04, 8'h0B);
    wr(5'h05, 8'h0F);
    for (int k = 0; k < 5; k++) begin
      if (k == 4) wr(5'h05, 8'h0F);
      wr(5'h00, v);
      conv(1'b1);
    end
    wr(5'h09, 8'h5A);
    st();
    $display("Test restart done");
    wr(5'h06, 8'h11);
    wr(5'h00, v);
    conv(1'b1);
    st();
    wr(5'h08, 8'hA5);
    chk(irqRequest, irq);
    wr(5'h09, 8'h00);
    wr(5'h06, 8'h31);
    for (int k = 0; k < 4; k++) begin
      wr(5'h00, v);
      conv(1'b1);
    end
    wr(5'h08, 8'h00);
    wr(5'h09, 8'h00);
    st();
    $display("Test interrupt done");
    wr(5'h06, 8'h02);
    pin(0, 1'b1);
    wr(5'h06, 8'h04);
    pin(1, 1'b1);
    wr(5'h06, 8'h0C);
    pin(1, 1'b0);
    pins[2] = 1'b1;
    pin(1, 1'b1);
    wr(5'h09, 8'h00);
    wr(5'h06, 8'h00);
    $display("Test pins done");
    wr(5'h0A, 8'($random(seed)));
    chk(analogOutValue, aout);
    wr(5'h0B, 8'($random(seed)));
    chk(analogOutValue, aout);
    $display("Test output done");
    conclude();
  end
endmodule
